/* dv/display_scan_config_test.sv */
`timescale 1ns/1ps
module display_scan_config_test;
	logic mclk, rst_n, regWr, regRd, frameStart, hs, vs, act, bor, pixelValid, cursorIn, odd, mark;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic pixelAdvance, cursorOut, interlacedMode, planarMode, blinkPhaseOut, th, tv, ph, pv, qual;
	logic [7:0] pixelOut;
	logic [15:0] qualCount, q0;
	int errors, compares, cycles, n;
	// Row: config bits 12..8, then hsync, vsync, active, border, then tube h/v, panel h/v, qualifier.
	logic [13:0] rows [6] = '{14'b00000_1010_10101, 14'b00000_0101_01010, 14'b11111_1001_01011,
		14'b11111_0100_10100, 14'b01010_1111_10101, 14'b10101_1101_01011};
	display_scan_config dut_u (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .frameStart(frameStart), .hSyncActive(hs),
		.vSyncActive(vs), .lineActive(act), .lineBorder(bor), .oddField(odd), .pixelValid(pixelValid),
		.pixelIn(8'h5A), .pixelBlinkMark(mark), .cursorIn(cursorIn), .pixelAdvance(pixelAdvance),
		.pixelOut(pixelOut), .cursorOut(cursorOut), .interlacedMode(interlacedMode), .planarMode(planarMode),
		.blinkPhaseOut(blinkPhaseOut), .tube_horizontal_sync_out(th), .tube_vertical_sync_out(tv),
		.panelHSyncOut(ph), .panelVSyncOut(pv), .panel_display_qualifier(qual));
	display_sink sink_u (.mclk(mclk), .rst_n(rst_n), .panel_display_qualifier(qual), .qualCount(qualCount));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 check(regRdata, exp);
	endtask
	task automatic frame();
		@(posedge mclk);
		frameStart <= 1'b1;
		@(posedge mclk);
		frameStart <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic countAdv(input int exp);
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			#1 n += int'(pixelAdvance === 1'b1);
		end
		check(n, exp);
	endtask
	task automatic results();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			results();
		end
	end
	initial begin
		{regWr, regRd, frameStart, hs, vs, act, bor, pixelValid, cursorIn, odd, mark} = '0;
		{regAddr, regWdata, errors, compares, cycles} = '0;
		rst_n = 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		#1 check({th, tv, ph, pv, qual, blinkPhaseOut}, 32'h0000_0001);
		rd(display_scan_pkg::TIMING_CFG_ADDR, display_scan_pkg::CFG_RESET);
		wr(display_scan_pkg::TIMING_CFG_ADDR, 32'hFFFF_FFFF);
		rd(display_scan_pkg::TIMING_CFG_ADDR, display_scan_pkg::CFG_WRITE_MASK);
		rd(8'h10, 32'h0000_0000);
		wr(8'h10, 32'hFFFF_FFFF);
		#1 check({interlacedMode, planarMode, th}, 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			wr(display_scan_pkg::TIMING_CFG_ADDR, {19'h0_0000, rows[i][13:9], 8'h00});
			{hs, vs, act, bor} <= rows[i][8:5];
			frame();
			check({th, tv, ph, pv, qual}, rows[i][4:0]);
		end
		// The panel counts as powered down here, so interlace may be switched on.
		wr(display_scan_pkg::TIMING_CFG_ADDR, 32'h0000_6100);
		{hs, vs, act, bor} <= 4'b0001;
		repeat (2) @(posedge mclk);
		#1 check({interlacedMode, planarMode, th}, 32'h0000_0001);
		frame();
		check({interlacedMode, planarMode, th}, 32'h0000_0007);
		q0 = qualCount;
		@(posedge mclk);
		odd <= 1'b1;
		frame();
		check(qualCount, q0);
		rd(display_scan_pkg::STATUS_ADDR, 32'h0000_0006);
		@(posedge mclk);
		act <= 1'b1;
		pixelValid <= 1'b1;
		countAdv(8);
		wr(display_scan_pkg::TIMING_CFG_ADDR, 32'h0000_8000);
		frame();
		countAdv(4);
		wr(display_scan_pkg::TIMING_CFG_ADDR, 32'h0000_0080);
		cursorIn <= 1'b1;
		repeat (20) frame();
		check({blinkPhaseOut, cursorOut}, 32'h0000_0000);
		check(pixelOut, 32'h0000_005A);
		@(posedge mclk);
		mark <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 check(pixelOut, 32'h0000_0000);
		wr(display_scan_pkg::TIMING_CFG_ADDR, 32'h0001_0080);
		repeat (20) frame();
		check(blinkPhaseOut, 32'h0000_0000);
		repeat (12) frame();
		check({blinkPhaseOut, cursorOut, pixelOut}, 32'h0000_035A);
		rd(display_scan_pkg::STATUS_ADDR, 32'h0000_0004);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(display_scan_pkg::TIMING_CFG_ADDR, display_scan_pkg::CFG_RESET);
		check({interlacedMode, blinkPhaseOut}, 32'h0000_0001);
		results();
	end
endmodule

/* dv/display_sink.sv */
`timescale 1ns/1ps
module display_sink (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Panel pin
	input wire logic panel_display_qualifier,
	// Observed count
	output logic [15:0] qualCount
);
	// The panel latches pixels only while the qualifier is high, so this is what it would show.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			qualCount <= 16'h0000;
		end else if (panel_display_qualifier) begin
			qualCount <= qualCount + 16'h0001;
		end
	end
endmodule

/* hw/blink_timer.sv */
`timescale 1ns/1ps
module blink_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Configuration
	scan_cfg_if.user cfg
);
	logic [display_scan_pkg::BLINK_CNT_W-1:0] frameCount;
	logic phase;
	wire logic [display_scan_pkg::BLINK_CNT_W-1:0] halfPeriod;
	wire logic wrap;
	assign halfPeriod = cfg.blinkRate ? display_scan_pkg::BLINK_SLOW_FRAMES
		: display_scan_pkg::BLINK_FAST_FRAMES;
	assign wrap = frameCount >= halfPeriod - 6'h1;
	// When blinking is off the phase rests visible so nothing flickers.
	assign cfg.blinkPhase = cfg.blinkOn ? phase : 1'b1;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frameCount <= '0;
			phase <= 1'b1;
		end else if (!cfg.blinkOn) begin
			frameCount <= '0;
			phase <= 1'b1;
		end else if (cfg.frameStart) begin
			frameCount <= wrap ? '0 : frameCount + 6'h1;
			phase <= wrap ? ~phase : phase;
		end
	end
	property p_blink_toggle;
		@(posedge mclk) disable iff (!rst_n)
		cfg.blinkOn && cfg.frameStart && wrap && $past(cfg.blinkOn) |=> phase != $past(phase);
	endproperty
	a_blink_toggle: assert property (p_blink_toggle) else $error("blink phase did not toggle");
endmodule

/* hw/display_scan_config.sv */
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - When pixel repeat is set each fetched pixel is shown twice across the line.
// - The interlace bit chooses between non-interlaced and interlaced scan generation.
// - With centering on the panel qualifier covers border and active parts, otherwise only active.
// - The panel vertical sync idles low and pulses high at 0, the reverse at 1.
// - The panel horizontal sync idles low and pulses high at 0, the reverse at 1.
// - The tube vertical sync idles low and pulses high at 0, the reverse at 1.
// - The tube horizontal sync idles low and pulses high at 0, the reverse at 1.
// - The blink bit enables blinking of the cursor and of pixels marked to blink.
// - The blink period follows the blink rate bit at position 16.
module display_scan_config (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Timing generator
	input wire logic frameStart,
	input wire logic hSyncActive,
	input wire logic vSyncActive,
	input wire logic lineActive,
	input wire logic lineBorder,
	input wire logic oddField,
	// Pixel path
	input wire logic pixelValid,
	input wire logic [7:0] pixelIn,
	input wire logic pixelBlinkMark,
	input wire logic cursorIn,
	output logic pixelAdvance,
	output logic [7:0] pixelOut,
	output logic cursorOut,
	// Mode outputs
	output logic interlacedMode,
	output logic planarMode,
	output logic blinkPhaseOut,
	// Display pins
	output logic tube_horizontal_sync_out,
	output logic tube_vertical_sync_out,
	output logic panelHSyncOut,
	output logic panelVSyncOut,
	output logic panel_display_qualifier
);
	logic [31:0] shadow;
	logic [31:0] active;
	logic [31:0] next_rdata;
	logic repeatPhase;
	display_scan_pkg::field_e field;
	scan_cfg_if cfgBus ();

	function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	// Software sees the written shadow; hardware runs on the frame-aligned copy.
	wire logic cfgWrite = regWr && addrHit(regAddr, display_scan_pkg::TIMING_CFG_ADDR);
	wire logic cfgRead = regRd && addrHit(regAddr, display_scan_pkg::TIMING_CFG_ADDR);
	wire logic statRead = regRd && addrHit(regAddr, display_scan_pkg::STATUS_ADDR);
	wire logic [31:0] statusWord = {29'h0000_0000, blinkPhaseOut, field == display_scan_pkg::FIELD_ODD,
		repeatPhase};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shadow <= display_scan_pkg::CFG_RESET;
		end else if (cfgWrite) begin
			shadow <= regWdata & display_scan_pkg::CFG_WRITE_MASK;
		end
	end

	// Applying at frame start avoids a sync pulse that begins in one polarity and ends in another.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			active <= display_scan_pkg::CFG_RESET;
		end else if (frameStart) begin
			active <= shadow;
		end
	end

	assign next_rdata = cfgRead ? shadow : (statRead ? statusWord : 32'h0000_0000);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 32'h0000_0000;
		end else begin
			regRdata <= next_rdata;
		end
	end

	assign cfgBus.pixelRepeat = active[display_scan_pkg::PIXEL_REPEAT_BIT];
	assign cfgBus.interlaced = active[display_scan_pkg::INTERLACE_BIT];
	assign cfgBus.planar = active[display_scan_pkg::PLANAR_BIT];
	assign cfgBus.blinkOn = active[display_scan_pkg::BLINK_ON_BIT];
	assign cfgBus.blinkRate = active[display_scan_pkg::BLINK_RATE_BIT];
	assign cfgBus.frameStart = frameStart;

	blink_timer blinker (
		.mclk(mclk),
		.rst_n(rst_n),
		.cfg(cfgBus)
	);

	// Field tracking for interlaced scan; progressive scan stays on the even field.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			field <= display_scan_pkg::FIELD_EVEN;
		end else if (frameStart) begin
			field <= (shadow[display_scan_pkg::INTERLACE_BIT] && oddField) ? display_scan_pkg::FIELD_ODD
				: display_scan_pkg::FIELD_EVEN;
		end
	end

	// Pixel repeat: a pixel is requested only every second pixel clock, so each shows twice.
	wire logic next_repeatPhase = cfgBus.pixelRepeat && lineActive ? ~repeatPhase : 1'b0;
	assign pixelAdvance = lineActive && (!cfgBus.pixelRepeat || repeatPhase);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			repeatPhase <= 1'b0;
		end else begin
			repeatPhase <= next_repeatPhase;
		end
	end

	wire logic blinkHide = cfgBus.blinkOn && !cfgBus.blinkPhase;
	wire logic borderQualify = active[display_scan_pkg::CENTER_BIT] ? (lineActive || lineBorder)
		: lineActive;
	wire logic next_tubeH = hSyncActive ^ active[display_scan_pkg::THSP_BIT];
	wire logic next_tubeV = vSyncActive ^ active[display_scan_pkg::TVSP_BIT];
	wire logic next_panelH = hSyncActive ^ active[display_scan_pkg::PHSP_BIT];
	wire logic next_panelV = vSyncActive ^ active[display_scan_pkg::PVSP_BIT];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tube_horizontal_sync_out <= 1'b0;
			tube_vertical_sync_out <= 1'b0;
			panelHSyncOut <= 1'b0;
			panelVSyncOut <= 1'b0;
			panel_display_qualifier <= 1'b0;
			pixelOut <= 8'h00;
			cursorOut <= 1'b0;
		end else begin
			tube_horizontal_sync_out <= next_tubeH;
			tube_vertical_sync_out <= next_tubeV;
			panelHSyncOut <= next_panelH;
			panelVSyncOut <= next_panelV;
			panel_display_qualifier <= borderQualify;
			pixelOut <= (pixelValid && !(pixelBlinkMark && blinkHide)) ? pixelIn : 8'h00;
			cursorOut <= cursorIn && !blinkHide;
		end
	end

	assign interlacedMode = cfgBus.interlaced;
	assign planarMode = cfgBus.planar;
	assign blinkPhaseOut = cfgBus.blinkPhase;

	property p_tube_h;
		@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> tube_horizontal_sync_out == ($past(hSyncActive) ^ $past(active[display_scan_pkg::THSP_BIT]));
	endproperty
	a_tube_h: assert property (p_tube_h) else $error("tube hsync polarity wrong");
	property p_tube_v;
		@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> tube_vertical_sync_out == ($past(vSyncActive) ^ $past(active[display_scan_pkg::TVSP_BIT]));
	endproperty
	a_tube_v: assert property (p_tube_v) else $error("tube vsync polarity wrong");
	property p_panel_h;
		@(posedge mclk) disable iff (!rst_n)
		!hSyncActive && !active[display_scan_pkg::PHSP_BIT] |=> !panelHSyncOut;
	endproperty
	a_panel_h: assert property (p_panel_h) else $error("panel hsync not idle low");
	property p_panel_v;
		@(posedge mclk) disable iff (!rst_n)
		vSyncActive && active[display_scan_pkg::PVSP_BIT] |=> !panelVSyncOut;
	endproperty
	a_panel_v: assert property (p_panel_v) else $error("panel vsync pulse not low");
	property p_center;
		@(posedge mclk) disable iff (!rst_n)
		lineBorder && !lineActive |=> panel_display_qualifier == $past(active[display_scan_pkg::CENTER_BIT]);
	endproperty
	a_center: assert property (p_center) else $error("border qualify wrong");
	sequence s_pair_start;
		lineActive && cfgBus.pixelRepeat && !repeatPhase;
	endsequence
	sequence s_pair_finish;
		!pixelAdvance ##1 (!(lineActive && cfgBus.pixelRepeat) || pixelAdvance);
	endsequence
	property p_repeat;
		@(posedge mclk) disable iff (!rst_n)
		s_pair_start |-> s_pair_finish;
	endproperty
	a_repeat: assert property (p_repeat) else $error("pixel repeat cadence wrong");
	property p_single;
		@(posedge mclk) disable iff (!rst_n)
		lineActive && !cfgBus.pixelRepeat |-> pixelAdvance;
	endproperty
	a_single: assert property (p_single) else $error("pixel not advanced");
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		!frameStart |=> active == $past(active);
	endproperty
	a_hold: assert property (p_hold) else $error("config changed mid frame");
	property p_blink_off;
		@(posedge mclk) disable iff (!rst_n)
		!cfgBus.blinkOn && cursorIn |=> cursorOut;
	endproperty
	a_blink_off: assert property (p_blink_off) else $error("cursor hidden with blink off");
	property p_blink_pixel;
		@(posedge mclk) disable iff (!rst_n)
		pixelValid && pixelBlinkMark && blinkHide |=> pixelOut == 8'h00;
	endproperty
	a_blink_pixel: assert property (p_blink_pixel) else $error("marked pixel shown while hidden");
endmodule

/* hw/display_scan_pkg.sv */
package display_scan_pkg;
	localparam logic [7:0] TIMING_CFG_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0C;
	localparam int PIXEL_REPEAT_BIT = 15;
	localparam int INTERLACE_BIT = 14;
	localparam int PLANAR_BIT = 13;
	localparam int CENTER_BIT = 12;
	localparam int PVSP_BIT = 11;
	localparam int PHSP_BIT = 10;
	localparam int TVSP_BIT = 9;
	localparam int THSP_BIT = 8;
	localparam int BLINK_ON_BIT = 7;
	localparam int BLINK_RATE_BIT = 16;
	localparam logic [31:0] CFG_WRITE_MASK = 32'h0001_FF80;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam int BLINK_CNT_W = 6;
	localparam logic [5:0] BLINK_FAST_FRAMES = 6'h10;
	localparam logic [5:0] BLINK_SLOW_FRAMES = 6'h20;
	typedef enum logic [1:0] {
		FIELD_EVEN = 2'b01,
		FIELD_ODD = 2'b10
	} field_e;
endpackage

/* hw/scan_cfg_if.sv */
`timescale 1ns/1ps
interface scan_cfg_if;
	logic pixelRepeat;
	logic interlaced;
	logic planar;
	logic blinkOn;
	logic blinkRate;
	logic frameStart;
	logic blinkPhase;
	modport owner(output pixelRepeat, interlaced, planar, blinkOn, blinkRate, frameStart, input blinkPhase);
	modport user(input pixelRepeat, interlaced, planar, blinkOn, blinkRate, frameStart, output blinkPhase);
endinterface
